// ===== codc_clock_output_divider.v
`timescale 1ns/10ps
`default_nettype none
`include "codc_regs.vh"

// How it works
// - Fourteen identical channels, configuration sets role.
// - Divider ratios one through 4094 from VCO.
// - Odd ratios: only ratio one keeps half duty.
// - Twelve-bit ratio built from MSB and LSB.
// - Coarse delay in whole VCO steps from coarse[4:1], max 15.
// - Launch always on the rising edge; coarse[0] unused here.
// - Fine delay exposed only on analog mux path.
// - Mux: divider, analog, pair partner, VCO.
// - Fundamental via ratio one or VCO code.
// - Enable qualified by start-up, pair, sleep.
// - Gate divider clock only while slip cycles remain.
// - Per-channel leaf controller handles central events.
// - Free-running timer, alignment tied, externally rephased.
// - SPI or input triggers align, pulse, slip.
// - Channels obey own accept bits and mode.
// - Pulse stream enables, phases, then disables channels.
// - Phase offset sets start phase and slips.
// - Mode 00 async; mode 11 pulse-only, ratio above 31.
// - Multislip repeats count, auto after align/pulse.
// - Align-accept toggles safely, rephases on align.
module codc_clock_output_divider #(
    parameter NUM_CH = `CODC_NUM_CH,
    parameter DIV_W = `CODC_DIV_W,
    parameter TIMER_W = `CODC_TIMER_W,
    parameter [TIMER_W-1:0] TIMER_PERIOD = 12'hFFF,
    parameter [11:0] PULSE_COUNT = 12'h004
) (
    // Clock and reset; clk_sys stands for the VCO clock.
    input wire clk_sys,
    input wire nrst,
    // Global controls.
    input wire sleepMode,
    input wire [`CODC_NUM_PAIRS-1:0] pairOutputEnables,
    input wire alignReqSpi,
    input wire pulseReqSpi,
    input wire slipReqSpi,
    input wire [1:0] generalPurposeInputAction,
    input wire generalPurposeInput,
    input wire extAlign,
    // Per-channel configuration, channel n in slice n.
    input wire [NUM_CH-1:0] chanEnable,
    input wire [NUM_CH*4-1:0] dividerMsb,
    input wire [NUM_CH*8-1:0] dividerLsb,
    input wire [NUM_CH*5-1:0] coarseDelay,
    input wire [NUM_CH*5-1:0] fineDelay,
    input wire [NUM_CH*2-1:0] muxSel,
    input wire [NUM_CH*2-1:0] startupMode,
    input wire [NUM_CH-1:0] slipAccept,
    input wire [NUM_CH-1:0] alignAccept,
    input wire [NUM_CH-1:0] multislipEnable,
    input wire [NUM_CH*12-1:0] multislipCount,
    input wire [NUM_CH*DIV_W-1:0] phaseOffset,
    // Outputs.
    output reg [NUM_CH-1:0] chanOut,
    output reg [NUM_CH*5-1:0] fineDelayOut,
    output reg [NUM_CH-1:0] chanRunning,
    output reg [NUM_CH-1:0] phaseBusy,
    output reg pulseActive,
    output reg [TIMER_W-1:0] timerValue
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // A channel may run only when its own bit, its pair bit and the
    // sleep state all agree. The same test feeds the divider and the
    // registered run flag; the divider also needs the dynamic window.
    function chanAllowed;
        input enBit;
        input [`CODC_NUM_PAIRS-1:0] pairs;
        input integer ch;
        input sleeping;
        begin
            chanAllowed = enBit & pairs[ch/2] & ~sleeping;
        end
    endfunction

    // Ratios 0 and 1 both run at the full rate, so both end at count 0.
    // Ratio 0 is what software writes when the mux bypasses the divider.
    function [DIV_W-1:0] terminalCount;
        input [DIV_W-1:0] r;
        begin
            if (r <= 12'h001) begin
                terminalCount = {DIV_W{1'b0}};
            end else begin
                terminalCount = r - 1'b1;
            end
        end
    endfunction

    // The start phase is the offset folded into the divider's own range,
    // so an offset larger than the ratio cannot strand the counter.
    function [DIV_W-1:0] startPhase;
        input [DIV_W-1:0] offset;
        input [DIV_W-1:0] lastCount;
        begin
            startPhase = offset % (lastCount + 1'b1);
        end
    endfunction

    // The analog delay code reaches the delay cell only while the mux
    // exposes that path; elsewhere the cell is parked at its shortest step.
    function [`CODC_FINE_W-1:0] fineCode;
        input [1:0] sel;
        input [`CODC_FINE_W-1:0] code;
        begin
            if (sel == `CODC_MUX_ANALOG) begin
                fineCode = code;
            end else begin
                fineCode = {`CODC_FINE_W{1'b0}};
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Central timer and event broadcast
    // ----------------------------------------------------------------
    // The timer never stops; alignment lands on its wrap so every channel
    // with alignAccept set in mode 00 is rephased on the same edge whatever the request time.
    reg [TIMER_W-1:0] timer_q;
    reg alignPend_q;
    reg pulsePend_q;
    reg [11:0] pulseCnt_q;
    reg gpiPrev_q;
    wire gpiRise = generalPurposeInput & ~gpiPrev_q;
    wire timerWrap = (timer_q == TIMER_PERIOD);
    wire alignReq = alignReqSpi | (gpiRise & (generalPurposeInputAction == 2'h1));
    wire pulseReq = pulseReqSpi | (gpiRise & (generalPurposeInputAction == 2'h2));
    wire slipReq = slipReqSpi | (gpiRise & (generalPurposeInputAction == 2'h3));
    wire alignEvt = alignPend_q & timerWrap;
    wire pulseStart = pulsePend_q & timerWrap & ~pulseActive;
    wire pulseEnd = pulseActive & timerWrap & (pulseCnt_q == 12'h001);

    always @(posedge clk_sys) begin
        if (!nrst) begin
            timer_q <= `CODC_TIMER_RST;
            alignPend_q <= 1'b0;
            pulsePend_q <= 1'b0;
            pulseCnt_q <= 12'h000;
            gpiPrev_q <= 1'b0;
            pulseActive <= 1'b0;
            timerValue <= `CODC_TIMER_RST;
        end else begin
            gpiPrev_q <= generalPurposeInput;
            if (extAlign || timerWrap) begin
                timer_q <= `CODC_TIMER_RST;
            end else begin
                timer_q <= timer_q + 1'b1;
            end
            timerValue <= timer_q;
            // A request arriving with the event keeps the pending flag.
            alignPend_q <= alignReq | (alignPend_q & ~alignEvt);
            pulsePend_q <= pulseReq | (pulsePend_q & ~pulseStart);
            if (pulseStart) begin
                pulseActive <= 1'b1;
                pulseCnt_q <= PULSE_COUNT;
            end else if (pulseEnd) begin
                pulseActive <= 1'b0;
                pulseCnt_q <= 12'h000;
            end else if (pulseActive && timerWrap) begin
                pulseCnt_q <= pulseCnt_q - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    wire [NUM_CH-1:0] divOut;
    wire [NUM_CH-1:0] slipBusy;

    genvar n;
    generate
        for (n = 0; n < NUM_CH; n = n + 1) begin : gCh
            wire [DIV_W-1:0] ratio = {dividerMsb[n*4+:4], dividerLsb[n*8+:8]};
            wire [1:0] mode = startupMode[n*2+:2];
            wire [1:0] sel = muxSel[n*2+:2];
            wire [4:0] coarse = coarseDelay[n*5+:5];
            wire dyn = (mode == `CODC_START_DYNAMIC) &&
                (ratio > `CODC_DYN_MIN_RATIO);
            // Enable: channel bit, pair bit, sleep, and dynamic window.
            wire runEn = chanAllowed(chanEnable[n], pairOutputEnables, n, sleepMode) &
                (~dyn | pulseActive);
            wire alignHit = alignAccept[n] & (mode == `CODC_START_ASYNC) & alignEvt;
            wire dynStart = dyn & pulseStart;
            wire rephase = alignHit | dynStart;
            reg [DIV_W-1:0] cnt_q;
            reg [11:0] slipLeft_q;
            reg divHi_q;
            reg [35:0] halfPipe_q;
            // Slip requests gated per channel; multislip repeats count.
            wire slipHit = slipAccept[n] & slipReq;
            wire autoSlip = slipAccept[n] & multislipEnable[n] & rephase;
            wire [11:0] slipLoad = multislipEnable[n] ?
                multislipCount[n*12+:12] : 12'h001;
            // Clock gate: count paused while slip cycles remain.
            wire gateHold = (slipLeft_q != 12'h000);
            wire [DIV_W-1:0] last = terminalCount(ratio);
            wire [DIV_W-1:0] half = {1'b0, ratio[DIV_W-1:1]};

            always @(posedge clk_sys) begin
                if (!nrst) begin
                    cnt_q <= {DIV_W{1'b0}};
                    slipLeft_q <= 12'h000;
                    divHi_q <= 1'b0;
                    halfPipe_q <= 36'h0;
                end else begin
                    if (slipHit || autoSlip) begin
                        slipLeft_q <= slipLoad;
                    end else if (gateHold) begin
                        slipLeft_q <= slipLeft_q - 1'b1;
                    end
                    // A stopped channel waits at its start phase, so the first
                    // edge after enable already has the programmed offset.
                    if (!runEn) begin
                        cnt_q <= startPhase(phaseOffset[n*DIV_W+:DIV_W], last);
                    end else if (rephase) begin
                        // Start phase comes from the per-channel offset.
                        cnt_q <= startPhase(phaseOffset[n*DIV_W+:DIV_W], last);
                    end else if (!gateHold) begin
                        cnt_q <= (cnt_q >= last) ? {DIV_W{1'b0}} : cnt_q + 1'b1;
                    end
                    // Half-period compare; ratio one toggles every edge.
                    // Odd ratios split at floor(N/2), so the high time falls
                    // half a cycle short of half the period.
                    if (ratio <= 12'h001) begin
                        divHi_q <= runEn & ~divHi_q;
                    end else begin
                        divHi_q <= runEn & (cnt_q < half);
                    end
                    halfPipe_q <= {halfPipe_q[34:0], divHi_q};
                end
            end

            // Coarse delay: integer cycles from coarse[4:1]; coarse[0] is not used,
            // and the retimer launches on the rising edge only.
            // This logic sees one clock edge only, so the odd half step of
            // coarse[0] is dropped rather than taken from a falling-edge launch;
            // whole steps are taken from the shift chain here.
            assign divOut[n] = halfPipe_q[coarse[4:1]];
            // The gated clock is held while slip cycles remain.
            assign slipBusy[n] = gateHold;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Retimer and output mux
    // ----------------------------------------------------------------
    // The pair partner is the other channel of the same pair. Code 11
    // has no faster clock to hand, so it toggles on every edge as the
    // stand-in for the raw VCO; users must not read its rate literally.
    // Every output is registered, so all of them lag their inputs by one
    // edge alike and keep their relative phase.
    integer k;
    always @(posedge clk_sys) begin
        if (!nrst) begin
            chanOut <= {NUM_CH{1'b0}};
            fineDelayOut <= {NUM_CH*5{1'b0}};
            chanRunning <= {NUM_CH{1'b0}};
            phaseBusy <= {NUM_CH{1'b0}};
        end else begin
            for (k = 0; k < NUM_CH; k = k + 1) begin
                case (muxSel[k*2+:2])
                    `CODC_MUX_DIV: chanOut[k] <= divOut[k];
                    `CODC_MUX_ANALOG: chanOut[k] <= divOut[k];
                    `CODC_MUX_PAIR: chanOut[k] <= divOut[k ^ 1];
                    `CODC_MUX_VCO: chanOut[k] <= ~chanOut[k];
                    default: chanOut[k] <= 1'b0;
                endcase
                // Fine delay code drives the analog cell only on that path.
                fineDelayOut[k*5+:5] <= fineCode(muxSel[k*2+:2], fineDelay[k*5+:5]);
                chanRunning[k] <= chanAllowed(chanEnable[k], pairOutputEnables, k,
                    sleepMode);
                phaseBusy[k] <= slipBusy[k];
            end
        end
    end

endmodule
`default_nettype wire

// ===== codc_regs.vh
`ifndef CODC_REGS_VH
`define CODC_REGS_VH
// Channel count and divider field widths.
`define CODC_NUM_CH 14
`define CODC_NUM_PAIRS 7
`define CODC_DIV_W 12
`define CODC_DIV_MAX 12'hFFE
`define CODC_PHASE_W 5
`define CODC_FINE_W 5
`define CODC_MULTI_W 12
// Output mux codes.
`define CODC_MUX_DIV 2'h0
`define CODC_MUX_ANALOG 2'h1
`define CODC_MUX_PAIR 2'h2
`define CODC_MUX_VCO 2'h3
// Start-up modes.
`define CODC_START_ASYNC 2'h0
`define CODC_START_DYNAMIC 2'h3
// Smallest ratio allowed in dynamic mode is one above this.
`define CODC_DYN_MIN_RATIO 12'h01F
// Internal timer width and reset value.
`define CODC_TIMER_W 12
`define CODC_TIMER_RST 12'h000
// Analog step, kept for reference only.
`define CODC_FINE_STEP_PS 25
`endif

// ===== codc_props.sv
`timescale 1ns/10ps
`default_nettype none
module codc_props #(
    parameter [11:0] TIMER_PERIOD = 12'h00F
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic sleepMode,
    input wire logic [6:0] pairOutputEnables,
    input wire logic slipReqSpi,
    input wire logic pulseReqSpi,
    input wire logic extAlign,
    input wire logic [13:0] chanEnable,
    input wire logic [69:0] fineDelay,
    input wire logic [27:0] muxSel,
    input wire logic [13:0] slipAccept,
    input wire logic [13:0] chanRunning,
    input wire logic [69:0] fineDelayOut,
    input wire logic [13:0] phaseBusy,
    input wire logic pulseActive,
    input wire logic [11:0] timerValue
);
    logic [13:0] runExp;
    logic [69:0] fineExp;
    always_comb begin
        for (int k = 0; k < 14; k++) begin
            runExp[k] = chanEnable[k] & pairOutputEnables[k/2] & ~sleepMode;
            fineExp[k*5 +: 5] = (muxSel[k*2 +: 2] == 2'h1) ? fineDelay[k*5 +: 5] : 5'h00;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    rst_clear_a: assert property ($rose(nrst) |-> chanRunning == 14'h0000)
        else $error("run flags not clear after reset");
    run_gate_a: assert property ($past(nrst) |-> chanRunning == $past(runExp))
        else $error("run flags do not follow enables");
    fine_path_a: assert property ($past(nrst) |-> fineDelayOut == $past(fineExp))
        else $error("fine delay shown off the analog path");
    slip_start_a: assert property (slipReqSpi && slipAccept[0] |-> ##[1:3] phaseBusy[0])
        else $error("accepted slip never started");
    slip_refuse_a: assert property (!slipAccept[1] [*4] |-> !phaseBusy[1])
        else $error("slip taken without acceptance");
    timer_zero_a: assert property (extAlign |-> ##[1:2] timerValue == 12'h000)
        else $error("timer not rephased");
    timer_step_a: assert property ($past(nrst, 3) && !$past(extAlign) && !$past(extAlign, 2)
        && $past(timerValue) != TIMER_PERIOD |-> timerValue == $past(timerValue) + 12'h001)
        else $error("timer did not advance");
    pulse_win_a: assert property (pulseReqSpi |-> ##[1:40] pulseActive)
        else $error("pulse stream never opened");
    cover property (slipReqSpi && slipAccept[0]);
    cover property ($rose(pulseActive));
    cover property (extAlign);
endmodule
bind codc_clock_output_divider codc_props #(.TIMER_PERIOD(TIMER_PERIOD)) codc_props_i (
    .clk_sys, .nrst, .sleepMode, .pairOutputEnables, .slipReqSpi, .pulseReqSpi, .extAlign,
    .chanEnable, .fineDelay, .muxSel, .slipAccept, .chanRunning, .fineDelayOut, .phaseBusy,
    .pulseActive, .timerValue);
`default_nettype wire

// ===== codc_rx_model.sv
`timescale 1ns/10ps
`default_nettype none
// -------------------------------------------
// Receiver measuring period and high time.
// -------------------------------------------
module codc_rx_model (
    input wire logic clk_sys,
    input wire logic clkIn,
    output logic [15:0] period = 16'h0000,
    output logic [15:0] highLen = 16'h0000
);
    logic [15:0] cnt = 16'h0000;
    logic [15:0] hcnt = 16'h0000;
    logic prev = 1'b0;
    always @(posedge clk_sys) begin
        prev <= clkIn;
        if (clkIn && !prev) begin
            period <= cnt;
            highLen <= hcnt;
            cnt <= 16'h0001;
            hcnt <= 16'h0001;
        end else begin
            cnt <= cnt + 16'h0001;
            hcnt <= hcnt + {15'h0000, clkIn};
        end
    end
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
    logic clk_sys = 0, nrst = 0, sleepMode = 0, alignReqSpi = 0, pulseReqSpi = 0;
    logic slipReqSpi = 0, generalPurposeInput = 0, extAlign = 0;
    logic [6:0] pairOutputEnables = 7'h7F;
    logic [1:0] generalPurposeInputAction = 2'h0;
    logic [13:0] chanEnable = 14'h3FFF, slipAccept = 14'h0000, alignAccept = 14'h3FFF;
    logic [13:0] multislipEnable = 14'h0000, chanOut, chanRunning, phaseBusy;
    logic [55:0] dividerMsb = 56'h0;
    logic [111:0] dividerLsb = 112'h0;
    logic [69:0] fineDelay = 70'h0, coarseDelay = 70'h0, fineDelayOut;
    logic [27:0] muxSel = 28'h0, startupMode = 28'h0;
    logic [167:0] multislipCount = 168'h0, phaseOffset = 168'h0;
    logic pulseActive;
    logic [11:0] timerValue;
    logic [15:0] period, highLen;
    logic [13:0] enT [4] = '{14'h3FFF, 14'h2AAA, 14'h3FFF, 14'h0000};
    logic [6:0] prT [4] = '{7'h55, 7'h7F, 7'h7F, 7'h7F};
    logic slT [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic [13:0] exT [4] = '{14'h3333, 14'h2AAA, 14'h0000, 14'h0000};
    logic [11:0] rtT [3] = '{12'h003, 12'h004, 12'hFFE};
    int mismatches = 0, tests_run = 0, busyN = 0;
    codc_clock_output_divider #(.TIMER_PERIOD(12'h00F), .PULSE_COUNT(12'h002))
    codc_clock_output_divider_i (.clk_sys, .nrst, .sleepMode, .pairOutputEnables,
        .alignReqSpi, .pulseReqSpi, .slipReqSpi, .generalPurposeInputAction,
        .generalPurposeInput, .extAlign, .chanEnable, .dividerMsb, .dividerLsb, .coarseDelay,
        .fineDelay, .muxSel, .startupMode, .slipAccept, .alignAccept, .multislipEnable,
        .multislipCount, .phaseOffset, .chanOut, .fineDelayOut, .chanRunning, .phaseBusy,
        .pulseActive, .timerValue);
    codc_rx_model codc_rx_model_i (.clk_sys, .clkIn(chanOut[0]), .period, .highLen);
    initial forever #4 clk_sys = ~clk_sys;
    task cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task summarize;
        if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task trig(input logic viaGpi, input logic [1:0] act);
        if (viaGpi) begin
            generalPurposeInputAction = act;
            generalPurposeInput = 1;
        end else if (act == 2'h3) slipReqSpi = 1;
        else pulseReqSpi = 1;
        cyc(1);
        slipReqSpi = 0;
        pulseReqSpi = 0;
    endtask
    task slip_trial(input logic viaGpi);
        int seen;
        seen = 0;
        trig(viaGpi, 2'h3);
        repeat (4) begin
            if (phaseBusy[0] === 1'b1 && seen == 0) seen = 1;
            if (phaseBusy[1] !== 1'b0) seen = 2;
            cyc(1);
        end
        generalPurposeInput = 0;
        cyc(8);
        `CHK("slip busy", 1, seen)
    endtask
    task pulse_trial(input logic viaGpi);
        int n;
        n = 0;
        trig(viaGpi, 2'h2);
        while (pulseActive !== 1'b1 && n < 40) begin cyc(1); n++; end
        `CHK("pulse open", 1'b1, pulseActive)
        n = 0;
        while (pulseActive === 1'b1 && n < 100) begin cyc(1); n++; end
        `CHK("pulse length", 32, n)
        generalPurposeInput = 0;
        cyc(4);
    endtask
    initial begin
        cyc(8);
        `CHK("reset run", 14'h0000, chanRunning)
        nrst = 1;
        for (int i = 0; i < 4; i++) begin
            chanEnable = enT[i];
            pairOutputEnables = prT[i];
            sleepMode = slT[i];
            cyc(2);
            `CHK("run flags", exT[i], chanRunning)
        end
        chanEnable = 14'h3FFF;
        fineDelay = {14{5'h15}};
        muxSel = 28'h00000E1; // Ratios stay zero on the bypass codes.
        cyc(2);
        `CHK("fine out", 70'h15, fineDelayOut)
        muxSel = 28'h0;
        for (int i = 0; i < 3; i++) begin
            dividerMsb[3:0] = rtT[i][11:8];
            dividerLsb[7:0] = rtT[i][7:0];
            cyc(3 * rtT[i] + 10);
            `CHK("period", {4'h0, rtT[i]}, period)
            if (!rtT[i][0]) `CHK("high", {5'h00, rtT[i][11:1]}, highLen)
        end
        dividerLsb[7:0] = 8'h04;
        dividerMsb[3:0] = 4'h0;
        cyc(20);
        alignAccept = 14'h0000;
        cyc(3);
        alignAccept = 14'h3FFF;
        alignReqSpi = 1;
        cyc(1);
        alignReqSpi = 0;
        cyc(60);
        `CHK("period after align", 16'h0004, period)
        slipAccept = 14'h0001;
        slip_trial(0);
        slip_trial(1);
        multislipEnable = 14'h0001;
        multislipCount[11:0] = 12'h002; // Half of ratio four, as for a CMOS pair.
        trig(0, 2'h3);
        repeat (6) begin
            if (phaseBusy[0] === 1'b1) busyN++;
            cyc(1);
        end
        `CHK("multislip len", 2, busyN)
        multislipEnable = 14'h0000;
        pulse_trial(0);
        pulse_trial(1);
        dividerLsb[7:0] = 8'h00;
        dividerLsb[15:8] = 8'h06;
        muxSel[1:0] = 2'h2;
        cyc(30);
        `CHK("pair path", 16'h0006, period)
        muxSel[1:0] = 2'h3;
        cyc(10);
        `CHK("vco path", 16'h0002, period)
        muxSel[1:0] = 2'h0;
        dividerLsb[7:0] = 8'h01;
        cyc(10);
        `CHK("ratio one", 16'h0002, period)
        extAlign = 1;
        cyc(2);
        `CHK("timer", 12'h000, timerValue)
        extAlign = 0;
        cyc(40);
        summarize;
    end
    // A hang would otherwise run forever; the span is about four times the expected run.
    initial begin
        #400000;
        mismatches++;
        summarize;
    end
endmodule
`default_nettype wire
